// ### logic/crc_check_pkg.sv
// constants, register map and state codes for the write-data checksum checker
package crc_check_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h1;
  localparam logic [3:0] CRC_LO_ADDR = 4'h2;
  localparam logic [3:0] CRC_UP_ADDR = 4'h3;
  localparam logic [3:0] ERRCNT_ADDR = 4'h4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // control fields
  localparam int CTRL_CRC_EN = 0;
  localparam int CTRL_MASK_EN = 1;
  localparam int CTRL_WR_INV_EN = 2;
  localparam int CTRL_RD_INV_EN = 3;
  localparam int CTRL_PRE_2CK = 4;
  localparam int CTRL_PER_DEVICE = 5;
  localparam int CTRL_BL8_FIXED = 6;

  // sticky status fields, write one to clear; ST_BUSY is live burst state and is not cleared by a write
  localparam int ST_ERR_LO = 0;
  localparam int ST_ERR_UP = 1;
  localparam int ST_CONFLICT = 2;
  localparam int ST_SPACING = 3;
  localparam int ST_ORDER = 4;
  localparam int ST_MODE = 5;
  localparam int ST_CANCEL = 6;
  localparam int ST_BUSY = 8;

  // ****************************************
  // checksum and burst constants
  // ****************************************
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [3:0] LAST_DATA_BEAT = 4'h7;
  localparam logic [3:0] FIRST_CRC_BEAT = 4'h8;
  localparam logic [3:0] LAST_CRC_BEAT = 4'h9;
  localparam logic [2:0] FIXED_ORDER = 3'h0;
  localparam logic [3:0] SPACING_1CK = 4'h4;
  localparam logic [3:0] SPACING_2CK = 4'h6;
  localparam logic [3:0] ALERT_HOLD_CYCLES = 4'h6;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DATA = 4'b0010,
    ST_CRC = 4'b0100,
    ST_CHECK = 4'b1000
  } state_e;

endpackage

// ### logic/write_data_crc_checker.sv
// write-data checksum checker with commit gating for the array write path
//
// Strobed register access and the register offsets were decided locally.
module write_data_crc_checker #(
  parameter int LANES = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // column commands
  input wire logic col_cmd,
  input wire logic write_start,
  input wire logic [2:0] col_addr,
  input wire logic four_beat_burst_chop,
  input wire logic multipurpose_register_write,
  // received beats
  input wire logic beat_valid,
  input wire logic [15:0] dq,
  input wire logic lower_mask_inversion_lane,
  input wire logic upper_mask_inversion_lane,
  // array write path
  output logic array_write,
  output logic array_cancel,
  output logic [127:0] array_data,
  output logic [15:0] array_byte_mask,
  output logic array_upper_half,
  // error alert
  output logic error_alert_n
);
  initial begin
    if (LANES != 4 && LANES != 8 && LANES != 16) $error("LANES must be 4, 8 or 16");
  end
  // ****************************************
  // functions
  // ****************************************
  // remainder by unrolled division
  // generator x^8+x^2+x+1, 72 bits in one step, zero start, bit 71 first
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = crc_check_pkg::CRC_INIT;
    for (int i = 71; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? crc_check_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  // undo inversion and decode mask only on the way to the array
  function automatic logic [143:0] store_word(input logic [143:0] w, input logic inv);
    logic [143:0] s;
    s = w;
    for (int b = 0; b < 8; b++) begin
      for (int i = 0; i < 8; i++) begin
        if (inv && !w[64 + b]) s[i * 8 + b] = ~w[i * 8 + b];
        if (inv && !w[136 + b]) s[72 + i * 8 + b] = ~w[72 + i * 8 + b];
      end
    end
    return s;
  endfunction

  // ****************************************
  // control register fields
  // ****************************************
  logic [15:0] ctrl_reg, ctrl_next;
  logic crc_en, mask_en, wr_inv_en, persistent, inv_eff;
  assign crc_en = ctrl_reg[crc_check_pkg::CTRL_CRC_EN];
  assign mask_en = ctrl_reg[crc_check_pkg::CTRL_MASK_EN];
  assign wr_inv_en = ctrl_reg[crc_check_pkg::CTRL_WR_INV_EN];
  assign persistent = crc_en & mask_en;
  // on a forbidden mask/inversion mix the mask wins; inverting masked bytes is meaningless
  assign inv_eff = wr_inv_en & ~mask_en;

  // ****************************************
  // burst capture
  // ****************************************
  crc_check_pkg::state_e state_reg, state_next;
  logic [3:0] beat_reg, beat_next;
  logic [143:0] raw_reg, raw_next;
  logic [15:0] crc_rx_reg, crc_rx_next;
  logic half_reg, half_next;
  // lane-to-bit mapping per beat; unused positions stay at ones
  always_comb begin
    state_next = state_reg;
    beat_next = beat_reg;
    raw_next = raw_reg;
    crc_rx_next = crc_rx_reg;
    half_next = half_reg;
    case (state_reg)
      crc_check_pkg::ST_IDLE: begin
        if (write_start) begin
          state_next = crc_check_pkg::ST_DATA;
          beat_next = 4'h0;
          raw_next = '1;
          // column bit 2 picks the half carried by a chopped write
          half_next = four_beat_burst_chop & col_addr[2];
        end
      end
      crc_check_pkg::ST_DATA: begin
        if (beat_valid) begin
          // data lanes and mask lanes fill the code words
          for (int i = 0; i < 8; i++) begin
            if (i < LANES) raw_next[i * 8 + beat_reg[2:0]] = dq[i];
            if (i + 8 < LANES) raw_next[72 + i * 8 + beat_reg[2:0]] = dq[i + 8];
          end
          if (LANES >= 8) raw_next[64 + beat_reg[2:0]] = lower_mask_inversion_lane;
          if (LANES == 16) raw_next[136 + beat_reg[2:0]] = upper_mask_inversion_lane;
          beat_next = beat_reg + 4'h1;
          if (beat_reg == crc_check_pkg::LAST_DATA_BEAT) begin
            state_next = crc_en ? crc_check_pkg::ST_CRC : crc_check_pkg::ST_IDLE;
          end
        end
      end
      crc_check_pkg::ST_CRC: begin
        if (beat_valid) begin
          // 4-bit part splits the checksum over beats 8 and 9
          if (LANES == 4) begin
            if (beat_reg == crc_check_pkg::FIRST_CRC_BEAT) crc_rx_next[3:0] = dq[3:0];
            else crc_rx_next[7:4] = dq[3:0];
          end else if (beat_reg == crc_check_pkg::FIRST_CRC_BEAT) begin
            // beat 8 carries the whole checksum, beat 9 ones
            crc_rx_next = dq;
          end
          beat_next = beat_reg + 4'h1;
          if (beat_reg == crc_check_pkg::LAST_CRC_BEAT) state_next = crc_check_pkg::ST_CHECK;
        end
      end
      crc_check_pkg::ST_CHECK: state_next = crc_check_pkg::ST_IDLE;
      default: state_next = crc_check_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= crc_check_pkg::ST_IDLE;
      beat_reg <= 4'h0;
      raw_reg <= '1;
      crc_rx_reg <= 16'hffff;
      half_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      beat_reg <= beat_next;
      raw_reg <= raw_next;
      crc_rx_reg <= crc_rx_next;
      half_reg <= half_next;
    end
  end

  // ****************************************
  // checksum trees and compare
  // ****************************************
  logic [71:0] word_lo, word_up;
  logic [7:0] calc_lo, calc_up;
  logic err_lo, err_up, check_now;
  // 4-bit part forces bits 71..32 to ones
  assign word_lo = (LANES == 4) ? {40'hff_ffff_ffff, raw_reg[31:0]} : raw_reg[71:0];
  assign word_up = raw_reg[143:72];
  // two identical trees, lower and upper code word
  assign calc_lo = crc8(word_lo);
  assign calc_up = crc8(word_up);
  // any difference of the full remainder is an error
  assign err_lo = calc_lo != crc_rx_reg[7:0];
  assign err_up = (LANES == 16) && (calc_up != crc_rx_reg[15:8]);
  assign check_now = state_reg == crc_check_pkg::ST_CHECK;

  // ****************************************
  // array commit and alert
  // ****************************************
  logic write_reg, write_next, cancel_reg, cancel_next, half_out_reg, half_out_next;
  logic [127:0] data_reg, data_next;
  logic [15:0] bmask_reg, bmask_next;
  logic [3:0] alert_cnt_reg, alert_cnt_next;
  logic alert_n_reg, alert_n_next;
  logic early_commit;
  logic [143:0] src_word, st_word;
  assign early_commit = state_reg == crc_check_pkg::ST_DATA && beat_valid &&
                        beat_reg == crc_check_pkg::LAST_DATA_BEAT && !persistent;
  assign src_word = early_commit ? raw_next : raw_reg;
  assign st_word = store_word(src_word, inv_eff);
  always_comb begin
    write_next = 1'b0;
    cancel_next = 1'b0;
    data_next = data_reg;
    bmask_next = bmask_reg;
    half_out_next = half_out_reg;
    alert_cnt_next = (alert_cnt_reg != 4'h0) ? alert_cnt_reg - 4'h1 : 4'h0;
    for (int b = 0; b < 8; b++) begin
      data_next[b * 16 +: 8] = {st_word[56 + b], st_word[48 + b], st_word[40 + b],
                                st_word[32 + b], st_word[24 + b], st_word[16 + b],
                                st_word[8 + b], st_word[b]};
      data_next[b * 16 + 8 +: 8] = {st_word[128 + b], st_word[120 + b], st_word[112 + b],
                                    st_word[104 + b], st_word[96 + b], st_word[88 + b],
                                    st_word[80 + b], st_word[72 + b]};
      bmask_next[b * 2] = mask_en & ~src_word[64 + b];
      bmask_next[b * 2 + 1] = mask_en & ~src_word[136 + b];
    end
    // mask or checksum off: write as soon as the last data beat lands
    if (early_commit) begin
      write_next = 1'b1;
      half_out_next = half_reg;
    end
    // persistent mode: commit only a clean burst, else cancel
    if (check_now && persistent) begin
      write_next = !(err_lo || err_up);
      cancel_next = err_lo || err_up;
      half_out_next = half_reg;
    end
    // hold the alert low for a fixed window
    if (check_now && (err_lo || err_up)) alert_cnt_next = crc_check_pkg::ALERT_HOLD_CYCLES;
    alert_n_next = alert_cnt_next == 4'h0;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      write_reg <= 1'b0;
      cancel_reg <= 1'b0;
      data_reg <= '0;
      bmask_reg <= '0;
      half_out_reg <= 1'b0;
      alert_cnt_reg <= 4'h0;
      alert_n_reg <= 1'b1;
    end else begin
      write_reg <= write_next;
      cancel_reg <= cancel_next;
      data_reg <= data_next;
      bmask_reg <= bmask_next;
      half_out_reg <= half_out_next;
      alert_cnt_reg <= alert_cnt_next;
      alert_n_reg <= alert_n_next;
    end
  end
  assign array_write = write_reg;
  assign array_cancel = cancel_reg;
  assign array_data = data_reg;
  assign array_byte_mask = bmask_reg;
  assign array_upper_half = half_out_reg;
  assign error_alert_n = alert_n_reg;

  // ****************************************
  // controller-side fault watch
  // ****************************************
  logic [3:0] gap_reg, gap_next;
  logic conflict_ev, spacing_ev, order_ev, mode_ev;
  logic [3:0] bad_gap;
  assign bad_gap = ctrl_reg[crc_check_pkg::CTRL_PRE_2CK] ? crc_check_pkg::SPACING_2CK
                                                         : crc_check_pkg::SPACING_1CK;
  // write inversion and masking both on
  assign conflict_ev = wr_inv_en & mask_en;
  assign spacing_ev = crc_en && col_cmd && gap_reg == bad_gap;
  // fixed bursts must start at order 0:0:0
  assign order_ev = crc_en && write_start && ctrl_reg[crc_check_pkg::CTRL_BL8_FIXED] &&
                    !four_beat_burst_chop && col_addr != crc_check_pkg::FIXED_ORDER;
  assign mode_ev = crc_en && (multipurpose_register_write ||
                              ctrl_reg[crc_check_pkg::CTRL_PER_DEVICE]);
  // gap counts cycles since the last column command, saturating
  always_comb begin
    if (col_cmd) gap_next = 4'h1;
    else if (gap_reg != 4'h0 && gap_reg != 4'hf) gap_next = gap_reg + 4'h1;
    else gap_next = gap_reg;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) gap_reg <= 4'h0;
    else gap_reg <= gap_next;
  end

  // ****************************************
  // register port
  // ****************************************
  logic [6:0] status_reg, status_next, status_set;
  logic [15:0] errcnt_reg, errcnt_next, rdata_reg, rdata_next;
  assign status_set = {check_now && persistent && (err_lo || err_up), mode_ev, order_ev,
                       spacing_ev, conflict_ev, check_now && err_up, check_now && err_lo};
  // set wins over a clear in the same cycle
  always_comb begin
    ctrl_next = ctrl_reg;
    status_next = status_reg;
    errcnt_next = errcnt_reg;
    rdata_next = 16'h0000;
    if (reg_wr && reg_addr == crc_check_pkg::CTRL_ADDR) ctrl_next = reg_wdata;
    if (reg_wr && reg_addr == crc_check_pkg::STATUS_ADDR) status_next = status_reg & ~reg_wdata[6:0];
    if (reg_wr && reg_addr == crc_check_pkg::ERRCNT_ADDR) errcnt_next = 16'h0000;
    status_next = status_next | status_set;
    if (check_now && (err_lo || err_up) && errcnt_reg != 16'hffff) errcnt_next = errcnt_reg + 16'h1;
    if (reg_rd) begin
      case (reg_addr)
        crc_check_pkg::CTRL_ADDR: rdata_next = ctrl_reg;
        crc_check_pkg::STATUS_ADDR: rdata_next = {7'h00, state_reg != crc_check_pkg::ST_IDLE,
                                                  1'b0, status_reg};
        crc_check_pkg::CRC_LO_ADDR: rdata_next = {crc_rx_reg[7:0], calc_lo};
        crc_check_pkg::CRC_UP_ADDR: rdata_next = {crc_rx_reg[15:8], calc_up};
        crc_check_pkg::ERRCNT_ADDR: rdata_next = errcnt_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= crc_check_pkg::CTRL_RESET;
      status_reg <= 7'h00;
      errcnt_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      errcnt_reg <= errcnt_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence bad_check_s;
    check_now && persistent && (err_lo || err_up);
  endsequence
  chk_persist_no_write: assert property (bad_check_s |=> array_cancel && !array_write)
    else $error("bad burst reached the array");
  chk_mismatch_alert: assert property (check_now && (err_lo || err_up)
                                       |=> !error_alert_n [*6] ##1 error_alert_n)
    else $error("alert window wrong after mismatch");
  chk_early_commit: assert property (early_commit |=> array_write)
    else $error("unmasked write not committed after beat 7");
  // only a gap with no command between counts; mode is judged at the second command
  chk_gap_one_clk: assert property (col_cmd ##1 (!col_cmd) [*3] ##1 col_cmd && crc_en &&
                                    !ctrl_reg[crc_check_pkg::CTRL_PRE_2CK]
                                    |=> status_reg[crc_check_pkg::ST_SPACING])
    else $error("four-clock spacing not flagged");
  chk_gap_two_clk: assert property (col_cmd ##1 (!col_cmd) [*5] ##1 col_cmd && crc_en &&
                                    ctrl_reg[crc_check_pkg::CTRL_PRE_2CK]
                                    |=> status_reg[crc_check_pkg::ST_SPACING])
    else $error("six-clock spacing not flagged");
  chk_order_fault: assert property (order_ev |=> status_reg[crc_check_pkg::ST_ORDER])
    else $error("burst order fault not flagged");
  chk_upper_ones: assert property (LANES != 4 || &word_lo[71:32])
    else $error("upper code word bits not ones");
  chk_conflict_flag: assert property (wr_inv_en && mask_en
                                      |=> status_reg[crc_check_pkg::ST_CONFLICT])
    else $error("mask and inversion conflict not flagged");
  chk_inv_undone: assert property (early_commit && inv_eff && !raw_next[64]
                                   |=> array_data[0] == ~$past(raw_next[0]))
    else $error("inversion not undone before storing");
endmodule

// ### dv/burst_ctrl_model.sv
// controller-side model that forms checksum-protected write bursts
module burst_ctrl_model (
  // clock
  input wire logic core_clk,
  // command side
  output logic col_cmd,
  output logic write_start,
  output logic [2:0] col_addr,
  output logic four_beat_burst_chop,
  output logic multipurpose_register_write,
  // beat side
  output logic beat_valid,
  output logic [15:0] dq,
  output logic lower_mask_inversion_lane,
  output logic upper_mask_inversion_lane
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet command side at time zero
  initial begin
    {col_cmd, write_start, four_beat_burst_chop, multipurpose_register_write} = 4'h0;
    {beat_valid, col_addr, dq} = 20'h0a5a5;
    {lower_mask_inversion_lane, upper_mask_inversion_lane} = 2'h3;
  end

  // serial checksum reference
  // serial on purpose: shares nothing with a parallel xor tree
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 71; k >= 0; k--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // x16 beat layout, flip breaks checksum
  task automatic send_burst(input logic [143:0] cw, input logic [15:0] flip,
                            input logic [2:0] ca, input logic chop);
    logic [143:0] w;
    logic [15:0] crc;
    w = cw;
    for (int k = 0; k < 144; k++) begin
      if (chop && (k % 8) >= 4) begin
        w[k] = 1'b1;
      end
    end
    crc = {crc8(w[143:72]), crc8(w[71:0])} ^ flip;
    @(posedge core_clk);
    {write_start, col_cmd, col_addr, four_beat_burst_chop} <= {2'h3, ca, chop};
    for (int b = 0; b < 10; b++) begin
      @(posedge core_clk);
      {write_start, col_cmd, beat_valid} <= 3'h1;
      for (int i = 0; i < 8; i++) begin
        dq[i] <= (b > 7) ? (b == 8 ? crc[i] : 1'b1) : w[i * 8 + b];
        dq[8 + i] <= (b > 7) ? (b == 8 ? crc[8 + i] : 1'b1) : w[72 + i * 8 + b];
      end
      lower_mask_inversion_lane <= (b > 7) ? 1'b1 : w[64 + b];
      upper_mask_inversion_lane <= (b > 7) ? 1'b1 : w[136 + b];
    end
    @(posedge core_clk);
    beat_valid <= 1'b0;
    // released lines flip so a stale beat is never mistaken for data
    dq <= ~dq;
    lower_mask_inversion_lane <= ~lower_mask_inversion_lane;
    upper_mask_inversion_lane <= ~upper_mask_inversion_lane;
  endtask

  // two column commands a given gap apart
  task automatic col_pair(input int gap);
    @(posedge core_clk);
    col_cmd <= 1'b1;
    @(posedge core_clk);
    col_cmd <= 1'b0;
    repeat (gap - 1) @(posedge core_clk);
    col_cmd <= 1'b1;
    @(posedge core_clk);
    col_cmd <= 1'b0;
  endtask

  task automatic mpr_pulse();
    @(posedge core_clk);
    multipurpose_register_write <= 1'b1;
    @(posedge core_clk);
    multipurpose_register_write <= 1'b0;
  endtask
endmodule

// ### dv/write_data_crc_checker_tb.sv
// self-checking bench for the write-data checksum checker
module write_data_crc_checker_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [143:0] CW = {8'h7f, 64'h0123456789abcdef, 8'hfe, 64'hfedcba9876543210};
  logic core_clk, nrst, reg_wr, reg_rd, col_cmd, write_start, chop, multipurpose_register, beat_valid;
  logic lo_lane, up_lane, array_write, array_cancel, array_upper_half, error_alert_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dq, array_byte_mask, mask_seen, d;
  logic [2:0] col_addr;
  logic [127:0] array_data, data_seen;
  logic w_seen, c_seen, half_seen;
  int num_errors, comparisons, cycles, t_write, t_alert, n_low;

  write_data_crc_checker #(.LANES(16)) i_dut (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .col_cmd(col_cmd), .write_start(write_start),
    .col_addr(col_addr), .four_beat_burst_chop(chop), .multipurpose_register_write(multipurpose_register),
    .beat_valid(beat_valid), .dq(dq), .lower_mask_inversion_lane(lo_lane),
    .upper_mask_inversion_lane(up_lane), .array_write(array_write),
    .array_cancel(array_cancel), .array_data(array_data),
    .array_byte_mask(array_byte_mask), .array_upper_half(array_upper_half),
    .error_alert_n(error_alert_n));

  burst_ctrl_model i_ctrl (.core_clk(core_clk), .col_cmd(col_cmd),
    .write_start(write_start), .col_addr(col_addr), .four_beat_burst_chop(chop),
    .multipurpose_register_write(multipurpose_register), .beat_valid(beat_valid), .dq(dq),
    .lower_mask_inversion_lane(lo_lane), .upper_mask_inversion_lane(up_lane));

  // ****************************************
  // clock, reset and hang guard
  // ****************************************
  initial begin
    {core_clk, nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = 23'h0;
  end
  always #20 core_clk = ~core_clk;
  // whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // records first commit or cancel and the whole alert pulse
  task automatic watch();
    {w_seen, c_seen, t_write, t_alert, n_low} = '0;
    for (int n = 1; n <= 26; n++) begin
      @(posedge core_clk);
      #1;
      if ((array_write === 1'b1 || array_cancel === 1'b1) && t_write == 0) begin
        {t_write, w_seen, c_seen, half_seen} = {n, array_write, array_cancel, array_upper_half};
        {data_seen, mask_seen} = {array_data, array_byte_mask};
      end
      if (error_alert_n === 1'b0) begin
        n_low++;
        if (t_alert == 0) t_alert = n;
      end
    end
  endtask

  task automatic run(input logic [15:0] flip, input logic [2:0] ca, input logic chp);
    fork
      i_ctrl.send_burst(CW, flip, ca, chp);
      watch();
    join
  endtask

  // expected array word: lanes regrouped per beat, inverted bytes flipped back
  function automatic logic [127:0] exp_data(input logic inv);
    logic [127:0] e;
    for (int b = 0; b < 8; b++) begin
      for (int i = 0; i < 8; i++) begin
        e[b * 16 + i] = CW[i * 8 + b] ^ (inv & ~CW[64 + b]);
        e[b * 16 + 8 + i] = CW[72 + i * 8 + b] ^ (inv & ~CW[136 + b]);
      end
    end
    return e;
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    reg_read(crc_check_pkg::CTRL_ADDR, d);
    check("ctrl reset", crc_check_pkg::CTRL_RESET, d);
    reg_read(crc_check_pkg::STATUS_ADDR, d);
    check("status reset", 16'h0000, d);
    reg_write(4'hf, 16'hffff);
    reg_read(4'hf, d);
    check("unmapped read", 16'h0000, d);
    check("alert idle", 1'b1, error_alert_n);
    $display("test reset done");
  endtask

  task automatic t_good();
    logic [15:0] m;
    for (int b = 0; b < 8; b++) begin
      {m[b * 2], m[b * 2 + 1]} = {~CW[64 + b], ~CW[136 + b]};
    end
    reg_write(crc_check_pkg::CTRL_ADDR, 16'h0043);
    run(16'h0000, 3'h0, 1'b0);
    check("good commit", 2'h2, {w_seen, c_seen});
    check("commit cycle", 5'd13, t_write[4:0]);
    check("array data", exp_data(1'b0), data_seen);
    check("byte mask", m, mask_seen);
    check("no alert", 5'd0, n_low[4:0]);
    reg_read(crc_check_pkg::CRC_LO_ADDR, d);
    check("lower sums", {2{i_ctrl.crc8(CW[71:0])}}, d);
    reg_read(crc_check_pkg::CRC_UP_ADDR, d);
    check("upper sums", {2{i_ctrl.crc8(CW[143:72])}}, d);
    run(16'h0000, 3'h4, 1'b1);
    check("chop commit", 3'h5, {w_seen, c_seen, half_seen});
    $display("test good burst done");
  endtask

  task automatic t_bad();
    reg_write(crc_check_pkg::STATUS_ADDR, 16'h007f);
    run(16'h0001, 3'h0, 1'b0);
    check("cancel", 2'h1, {w_seen, c_seen});
    check("alert length", 5'd6, n_low[4:0]);
    check("alert with cancel", t_write[4:0], t_alert[4:0]);
    reg_read(crc_check_pkg::STATUS_ADDR, d);
    check("lower error flags", 7'h41, d[6:0]);
    reg_write(crc_check_pkg::STATUS_ADDR, 16'h007f);
    run(16'h0300, 3'h0, 1'b0);
    reg_read(crc_check_pkg::STATUS_ADDR, d);
    check("upper error flags", 7'h42, d[6:0]);
    reg_read(crc_check_pkg::ERRCNT_ADDR, d);
    check("error count", 16'h0002, d);
    $display("test bad burst done");
  endtask

  task automatic t_nomask();
    reg_write(crc_check_pkg::CTRL_ADDR, 16'h0001);
    reg_write(crc_check_pkg::STATUS_ADDR, 16'h007f);
    run(16'h0010, 3'h0, 1'b0);
    check("early commit", 2'h2, {w_seen, c_seen});
    check("commit before alert", 1'b1, t_write < t_alert);
    check("alert length", 5'd6, n_low[4:0]);
    reg_read(crc_check_pkg::STATUS_ADDR, d);
    check("flags no mask", 7'h01, d[6:0]);
    // inversion on, mask off: checksum over bits as received, bytes flipped back on store
    reg_write(crc_check_pkg::CTRL_ADDR, 16'h0005);
    run(16'h0000, 3'h0, 1'b0);
    check("inverted commit", 2'h2, {w_seen, c_seen});
    check("inverted data", exp_data(1'b1), data_seen);
    check("no mask", 16'h0000, mask_seen);
    check("inverted no alert", 5'd0, n_low[4:0]);
    $display("test unmasked write done");
  endtask

  // ctrl set first, then flags cleared, so only the new fault remains
  task automatic fault(input logic [15:0] ctrl, input int act, input logic [3:0] exp);
    reg_write(crc_check_pkg::CTRL_ADDR, ctrl);
    reg_write(crc_check_pkg::STATUS_ADDR, 16'h007f);
    if (act == 1) run(16'h0000, 3'h1, 1'b0);
    if (act == 2) i_ctrl.mpr_pulse();
    if (act >= 4) i_ctrl.col_pair(act);
    reg_read(crc_check_pkg::STATUS_ADDR, d);
    check("fault flags", exp, d[5:2]);
  endtask

  task automatic t_faults();
    fault(16'h0041, 1, 4'h4);
    fault(16'h0021, 0, 4'h8);
    fault(16'h0001, 2, 4'h8);
    fault(16'h0001, 4, 4'h2);
    fault(16'h0011, 6, 4'h2);
    fault(16'h0011, 4, 4'h0);
    fault(16'h0007, 0, 4'h1);
    fault(16'h000b, 0, 4'h0);
    $display("test fault flags done");
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_good();
    t_bad();
    t_nomask();
    t_faults();
    results();
  end
endmodule
